// ==== design/core_pkg.sv ====
package core_pkg;
  // Widths of the instruction word and its fields
  localparam int INSTR_W     = 14;
  localparam int DATA_W      = 8;
  localparam int FILE_ADDR_W = 7;
  localparam int PC_W        = 13;
  localparam int LIT_W       = 8;
  localparam int JUMP_W      = 11;
  localparam int BIT_W       = 3;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 3;
  localparam int REG_ADDR_W  = 2;

  // Field positions inside the word
  localparam int FMT_LO   = 12;
  localparam int OP_LO    = 8;
  localparam int DEST_BIT = 7;
  localparam int BPOS_LO  = 7;
  localparam int JSEL_BIT = 11;

  // Format prefixes in the two top bits
  localparam logic [1:0] FMT_BYTE = 2'h0;
  localparam logic [1:0] FMT_BIT  = 2'h1;
  localparam logic [1:0] FMT_FLOW = 2'h2;
  localparam logic [1:0] FMT_LIT  = 2'h3;

  // Byte operation codes
  localparam logic [3:0] BOP_MOVE_OUT = 4'h0;
  localparam logic [3:0] BOP_CLEAR    = 4'h1;
  localparam logic [3:0] BOP_SUB      = 4'h2;
  localparam logic [3:0] BOP_DEC      = 4'h3;
  localparam logic [3:0] BOP_OR       = 4'h4;
  localparam logic [3:0] BOP_AND      = 4'h5;
  localparam logic [3:0] BOP_XOR      = 4'h6;
  localparam logic [3:0] BOP_ADD      = 4'h7;
  localparam logic [3:0] BOP_MOVE     = 4'h8;
  localparam logic [3:0] BOP_INVERT   = 4'h9;
  localparam logic [3:0] BOP_INC      = 4'ha;
  localparam logic [3:0] BOP_DEC_SKIP = 4'hb;
  localparam logic [3:0] BOP_ROT_R    = 4'hc;
  localparam logic [3:0] BOP_ROT_L    = 4'hd;
  localparam logic [3:0] BOP_SWAP     = 4'he;
  localparam logic [3:0] BOP_INC_SKIP = 4'hf;

  // Literal sub-codes (upper bits only where the rest is don't care)
  localparam logic [1:0] LOP_LOAD  = 2'h0;
  localparam logic [1:0] LOP_RETV  = 2'h1;
  localparam logic [3:0] LOP_OR    = 4'h8;
  localparam logic [3:0] LOP_AND   = 4'h9;
  localparam logic [2:0] LOP_SUB   = 3'h6;
  localparam logic [2:0] LOP_ADD   = 3'h7;

  // Fixed control words
  localparam logic [INSTR_W-1:0] WORD_STANDBY = 14'h0063;
  localparam logic [INSTR_W-1:0] WORD_KICK    = 14'h0064;
  localparam logic [INSTR_W-1:0] WORD_RETURN  = 14'h0008;
  localparam logic [INSTR_W-1:0] WORD_IRET    = 14'h0009;

  // Register port map
  localparam logic [REG_ADDR_W-1:0] REG_CTRL   = 2'h0;
  localparam logic [REG_ADDR_W-1:0] REG_ACC    = 2'h1;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS = 2'h2;
  localparam logic [REG_ADDR_W-1:0] REG_PC_LO  = 2'h3;
  localparam int                    CTRL_RUN_BIT = 0;
  localparam logic                  RUN_RESET    = 1'b0;

  // Instruction cycle phases, Gray along the walk
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00, PH_Q2 = 2'b01, PH_Q3 = 2'b11, PH_Q4 = 2'b10
  } phase_t;

  typedef enum logic [3:0] {
    OP_PASS_B, OP_PASS_A, OP_ZERO, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
    OP_INVERT, OP_DEC, OP_INC, OP_ROT_L, OP_ROT_R, OP_SWAP, OP_BCLR, OP_BSET
  } alu_op_t;

  typedef enum logic [1:0] {SKIP_NONE, SKIP_ZERO, SKIP_BIT_LOW, SKIP_BIT_HIGH} skip_t;
  typedef enum logic [2:0] {FLOW_SEQ, FLOW_JUMP, FLOW_CALL, FLOW_RET, FLOW_IRET} flow_t;

  typedef struct packed {
    alu_op_t          op;
    logic             use_lit;
    logic             rd_file;
    logic             wr_file;
    logic             wr_acc;
    logic             upd_c;
    logic             upd_half;
    logic             upd_z;
    skip_t            skip;
    logic [BIT_W-1:0] bitpos;
    flow_t            flow;
    logic             standby;
    logic             kick;
  } decoded_t;

  // Order matches the status read-back, carry in bit 0
  typedef struct packed {
    logic watchdog_expired_flag;
    logic sleep_entered_flag;
    logic zero;
    logic half_overflow_bit;
    logic carry;
  } flags_t;
  localparam flags_t FLAGS_RESET = 5'h18;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic              carry;
    logic              half;
    logic              zero;
  } alu_out_t;

  typedef struct packed {
    logic [FILE_ADDR_W-1:0] addr;
    logic                   rd_en;
    logic                   wr_en;
    logic [DATA_W-1:0]      wr_data;
  } file_req_t;

  typedef struct packed {
    phase_t                            phase;
    logic [PC_W-1:0]                   program_counter;
    logic [INSTR_W-1:0]                instr;
    decoded_t                          dec;
    logic                              dummy;
    logic [DATA_W-1:0]                 acc;
    flags_t                            flags;
    logic [STACK_DEPTH-1:0][PC_W-1:0]  stack;
    logic [SP_W-1:0]                   sp;
    file_req_t                         file;
    logic                              run;
    logic                              standby;
    logic                              wdog_pulse;
    logic                              irq_pulse;
    logic [DATA_W-1:0]                 rdata;
  } state_t;
endpackage : core_pkg

// ==== design/alu_unit.sv ====
module alu_unit
  import core_pkg::*;
(
  input  wire alu_op_t           op,
  input  wire logic [DATA_W-1:0] acc,
  input  wire logic [DATA_W-1:0] operand,
  input  wire logic              carry_in,
  input  wire logic [BIT_W-1:0]  bit_pos,
  output alu_out_t               out
);
  logic [DATA_W:0] wide;      // Sum with carry out
  logic [4:0]      nib;       // Low nibble sum for the half carry
  logic [DATA_W-1:0] mask;    // One-hot bit select

  // Pure combinational datapath; flags are picked by the sequencer
  always_comb begin
    wide = {1'b0, operand};
    nib  = {1'b0, operand[3:0]};
    mask = DATA_W'(1) << bit_pos;
    out.carry = carry_in;
    unique case (op)
      OP_PASS_A: wide = {1'b0, acc};
      OP_ZERO:   wide = '0;
      OP_ADD: begin
        wide = {1'b0, operand} + {1'b0, acc};
        nib  = {1'b0, operand[3:0]} + {1'b0, acc[3:0]};
      end
      // Operand minus accumulator, carry set when no borrow
      OP_SUB: begin
        wide = {1'b0, operand} + {1'b0, ~acc} + (DATA_W+1)'(1);
        nib  = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
      end
      OP_AND:    wide = {1'b0, operand & acc};
      OP_OR:     wide = {1'b0, operand | acc};
      OP_XOR:    wide = {1'b0, operand ^ acc};
      OP_INVERT: wide = {1'b0, ~operand};
      OP_DEC:    wide = {1'b0, operand - DATA_W'(1)};
      OP_INC:    wide = {1'b0, operand + DATA_W'(1)};
      OP_ROT_L:  wide = {operand, carry_in};
      OP_ROT_R:  wide = {operand[0], carry_in, operand[DATA_W-1:1]};
      OP_SWAP:   wide = {1'b0, operand[3:0], operand[7:4]};
      OP_BCLR:   wide = {1'b0, operand & ~mask};
      OP_BSET:   wide = {1'b0, operand | mask};
      default:   wide = {1'b0, operand};
    endcase
    out.result = wide[DATA_W-1:0];
    out.carry  = wide[DATA_W];
    out.half   = nib[4];
    out.zero   = (wide[DATA_W-1:0] == '0);
  end
endmodule : alu_unit

// ==== design/instr_sequencer.sv ====
// Summary of operation
// - Every instruction is a 14-bit opcode-plus-operand word.
// - Destination bit picks accumulator or file register.
// - File address field is seven bits wide.
// - Bit field selects one bit of register.
// - Literal is 8 bits, jump target 11 bits.
// - Instruction cycle is four clock phases.
// - Taken test or flow change adds nop cycle.
// - File register is always read before writing.
// - Don't-care opcode bits accept either value.
// - Byte format: 00, op, dest, address.
// - Rotates through carry, only carry changes.
// - OR and XOR update only zero flag.
// - Decrement/increment skip on zero, no flags.
// - Bit format 01: clear, set, test-skip-low.
// - Test-skip-high skips when bit is set.
// - Literal OR and AND update zero flag.
// - Literal subtract and add update three flags.
// - Return with value loads literal, two cycles.
// - Standby word sets expired, clears entered flag.
//
// Implementation choices: the placing of the registers and strobed register access.
module instr_sequencer
  import core_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  output logic [PC_W-1:0]            prog_addr,
  input  wire logic [INSTR_W-1:0]    prog_word,
  output file_req_t                  file_req,
  input  wire logic [DATA_W-1:0]     file_rd_data,
  input  wire logic                  wake_req,
  output logic                       standby,
  output logic                       watchdog_clear,
  output logic                       irq_reenable,
  input  wire logic [REG_ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic [DATA_W-1:0]          reg_rdata
);
  state_t            st_q;       // Whole state of the core
  state_t            st_d;       // Next state
  decoded_t          dec_now;    // Decode of the word on the bus
  alu_out_t          alu_o;      // Datapath result
  logic [DATA_W-1:0] operand;    // Literal or file data
  logic              exec;       // Execute phase (Q3), nop cycles included
  logic              skip_taken; // Conditional test came true
  logic [SP_W-1:0]   sp_prev;    // Stack slot below the pointer

  // Field split of one word; x bits are simply never looked at
  function automatic decoded_t decode(input logic [INSTR_W-1:0] w);
    decoded_t r;
    logic [3:0] op4;
    logic       d;
    r = '0;
    r.op     = OP_PASS_B;
    r.skip   = SKIP_NONE;
    r.flow   = FLOW_SEQ;
    op4      = w[OP_LO+3:OP_LO];
    d        = w[DEST_BIT];
    r.bitpos = w[BPOS_LO+BIT_W-1:BPOS_LO];
    unique case (w[INSTR_W-1:FMT_LO])
      FMT_BYTE: begin
        // Read except for clear to accumulator and the no-operation family, then store by the destination bit
        r.rd_file = 1'b1;
        r.wr_file = d;
        r.wr_acc  = !d;
        r.upd_z   = 1'b1;
        unique case (op4)
          BOP_MOVE_OUT: begin
            r.upd_z = 1'b0;
            if (d) begin
              r.op = OP_PASS_A;
            end else begin
              // No-operation family holds the fixed words
              r.rd_file = 1'b0;
              r.wr_acc  = 1'b0;
              r.standby = (w == WORD_STANDBY);
              r.kick    = (w == WORD_KICK);
              if (w == WORD_RETURN) r.flow = FLOW_RET;
              if (w == WORD_IRET)   r.flow = FLOW_IRET;
            end
          end
          BOP_CLEAR: begin
            r.op = OP_ZERO;
            r.rd_file = d;
          end
          BOP_SUB: begin
            r.op = OP_SUB;
            r.upd_c = 1'b1;
            r.upd_half = 1'b1;
          end
          BOP_DEC:    r.op = OP_DEC;
          BOP_OR:     r.op = OP_OR;
          BOP_AND:    r.op = OP_AND;
          BOP_XOR:    r.op = OP_XOR;
          BOP_ADD: begin
            r.op = OP_ADD;
            r.upd_c = 1'b1;
            r.upd_half = 1'b1;
          end
          BOP_MOVE:   r.op = OP_PASS_B;
          BOP_INVERT: r.op = OP_INVERT;
          BOP_INC:    r.op = OP_INC;
          BOP_DEC_SKIP, BOP_INC_SKIP: begin
            r.op = (op4 == BOP_INC_SKIP) ? OP_INC : OP_DEC;
            r.upd_z = 1'b0;
            r.skip = SKIP_ZERO;
          end
          BOP_ROT_L, BOP_ROT_R: begin
            r.op = (op4 == BOP_ROT_L) ? OP_ROT_L : OP_ROT_R;
            r.upd_z = 1'b0;
            r.upd_c = 1'b1;
          end
          BOP_SWAP: begin
            r.op = OP_SWAP;
            r.upd_z = 1'b0;
          end
        endcase
      end
      FMT_BIT: begin
        r.rd_file = 1'b1;
        unique case (op4[3:2])
          2'h0: begin
            r.op = OP_BCLR;
            r.wr_file = 1'b1;
          end
          2'h1: begin
            r.op = OP_BSET;
            r.wr_file = 1'b1;
          end
          2'h2: r.skip = SKIP_BIT_LOW;
          2'h3: r.skip = SKIP_BIT_HIGH;
        endcase
      end
      FMT_FLOW: r.flow = w[JSEL_BIT] ? FLOW_JUMP : FLOW_CALL;
      FMT_LIT: begin
        r.use_lit = 1'b1;
        r.wr_acc  = 1'b1;
        if (op4[3:2] == LOP_LOAD) begin
          r.op = OP_PASS_B;
        end else if (op4[3:2] == LOP_RETV) begin
          r.flow = FLOW_RET;
        end else if (op4 == LOP_OR || op4 == LOP_AND) begin
          r.op = (op4 == LOP_OR) ? OP_OR : OP_AND;
          r.upd_z = 1'b1;
        end else if (op4[3:1] == LOP_SUB || op4[3:1] == LOP_ADD) begin
          r.op = (op4[3:1] == LOP_ADD) ? OP_ADD : OP_SUB;
          r.upd_z = 1'b1;
          r.upd_c = 1'b1;
          r.upd_half = 1'b1;
        end else begin
          // Unlisted literal codes leave everything alone
          r.wr_acc = 1'b0;
        end
      end
    endcase
    return r;
  endfunction : decode

  assign dec_now = decode(prog_word);
  assign exec    = (st_q.phase == PH_Q3);
  assign sp_prev = st_q.sp - SP_W'(1);
  // Literal comes from the low byte of the word
  assign operand = st_q.dec.use_lit ? st_q.instr[LIT_W-1:0] : file_rd_data;

  alu_unit u_alu (
    .op       (st_q.dec.op),
    .acc      (st_q.acc),
    .operand  (operand),
    .carry_in (st_q.flags.carry),
    .bit_pos  (st_q.dec.bitpos),
    .out      (alu_o)
  );

  // Test outcome for skipping instructions
  always_comb begin
    unique case (st_q.dec.skip)
      SKIP_ZERO:     skip_taken = alu_o.zero;
      SKIP_BIT_LOW:  skip_taken = !file_rd_data[st_q.dec.bitpos];
      SKIP_BIT_HIGH: skip_taken = file_rd_data[st_q.dec.bitpos];
      SKIP_NONE:     skip_taken = 1'b0;
    endcase
  end

  // Next-state logic for phases, registers and the port
  always_comb begin
    st_d = st_q;
    st_d.file.rd_en = 1'b0;
    st_d.file.wr_en = 1'b0;
    st_d.wdog_pulse = 1'b0;
    st_d.irq_pulse  = 1'b0;
    st_d.rdata      = '0;
    // Register port; only the run bit is writable
    if (reg_write && reg_addr == REG_CTRL) st_d.run = reg_wdata[CTRL_RUN_BIT];
    if (reg_read) begin
      unique case (reg_addr)
        REG_CTRL:   st_d.rdata = {{(DATA_W-1){1'b0}}, st_q.run};
        REG_ACC:    st_d.rdata = st_q.acc;
        REG_STATUS: st_d.rdata = {3'h0, st_q.flags};
        REG_PC_LO:  st_d.rdata = st_q.program_counter[DATA_W-1:0];
      endcase
    end
    // Wake clears standby; a standby word in the same cycle wins below
    if (wake_req) st_d.standby = 1'b0;
    unique case (st_q.phase)
      PH_Q1: begin
        // Halted or asleep cores wait here between cycles
        if (st_q.run && !st_q.standby) begin
          st_d.phase = PH_Q2;
          if (st_q.dummy) begin
            // Second cycle of a two-cycle instruction: a plain nop
            st_d.dummy = 1'b0;
            st_d.instr = '0;
            st_d.dec   = decode('0);
          end else begin
            st_d.instr = prog_word;
            st_d.dec   = dec_now;
            st_d.program_counter = st_q.program_counter + PC_W'(1);
            st_d.file.addr  = prog_word[FILE_ADDR_W-1:0];
            st_d.file.rd_en = dec_now.rd_file;
          end
        end
      end
      PH_Q2: st_d.phase = PH_Q3;
      PH_Q3: begin
        st_d.phase = PH_Q4;
        if (st_q.dec.wr_acc) st_d.acc = alu_o.result;
        if (st_q.dec.wr_file) begin
          st_d.file.wr_en   = 1'b1;
          st_d.file.wr_data = alu_o.result;
        end
        if (st_q.dec.upd_c)    st_d.flags.carry = alu_o.carry;
        if (st_q.dec.upd_half) st_d.flags.half_overflow_bit = alu_o.half;
        if (st_q.dec.upd_z)    st_d.flags.zero = alu_o.zero;
        if (st_q.dec.standby) begin
          st_d.flags.sleep_entered_flag    = 1'b0;
          st_d.flags.watchdog_expired_flag = 1'b1;
          st_d.standby    = 1'b1;
          st_d.wdog_pulse = 1'b1;
        end
        if (st_q.dec.kick) begin
          st_d.flags.sleep_entered_flag    = 1'b1;
          st_d.flags.watchdog_expired_flag = 1'b1;
          st_d.wdog_pulse = 1'b1;
        end
        // Flow change; the stack wraps like a ring, no overflow check
        unique case (st_q.dec.flow)
          FLOW_JUMP: st_d.program_counter = PC_W'(st_q.instr[JUMP_W-1:0]);
          FLOW_CALL: begin
            st_d.stack[st_q.sp] = st_q.program_counter;
            st_d.sp = st_q.sp + SP_W'(1);
            st_d.program_counter = PC_W'(st_q.instr[JUMP_W-1:0]);
          end
          FLOW_RET, FLOW_IRET: begin
            st_d.sp = sp_prev;
            st_d.program_counter = st_q.stack[sp_prev];
            st_d.irq_pulse = (st_q.dec.flow == FLOW_IRET);
          end
          FLOW_SEQ: ;
          default: ;
        endcase
        if (skip_taken) st_d.program_counter = st_q.program_counter + PC_W'(1);
        st_d.dummy = skip_taken || (st_q.dec.flow != FLOW_SEQ);
      end
      PH_Q4: st_d.phase = PH_Q1;
    endcase
  end

  // Single state register, synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q       <= '0;
      st_q.phase <= PH_Q1;
      st_q.flags <= FLAGS_RESET;
      st_q.run   <= RUN_RESET;
      st_q.dec   <= decode('0);
    end else begin
      st_q <= st_d;
    end
  end

  // All outputs straight from state flops
  assign prog_addr      = st_q.program_counter;
  assign file_req       = st_q.file;
  assign standby        = st_q.standby;
  assign watchdog_clear = st_q.wdog_pulse;
  assign irq_reenable   = st_q.irq_pulse;
  assign reg_rdata      = st_q.rdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence rest_of_cycle;
    st_q.phase == PH_Q2 ##1 st_q.phase == PH_Q3 ##1 st_q.phase == PH_Q4 ##1 st_q.phase == PH_Q1;
  endsequence
  sequence nop_body;
    !file_req.rd_en ##2 !file_req.wr_en;
  endsequence

  phase_walk_a: assert property ((st_q.phase == PH_Q1 && st_d.phase == PH_Q2) |=> rest_of_cycle)
    else $error("instruction cycle is not four clocks");
  rmw_read_a: assert property (file_req.wr_en |-> $past(file_req.rd_en, 2))
    else $error("file write without prior read");
  addr_field_a: assert property (file_req.rd_en |-> file_req.addr == st_q.instr[FILE_ADDR_W-1:0])
    else $error("file address not from low seven bits");
  dest_route_a: assert property ((exec && st_q.instr[13:12] == FMT_BYTE)
    |=> file_req.wr_en == st_q.instr[DEST_BIT])
    else $error("destination bit misrouted");
  nop_cycle_a: assert property ((exec && st_q.dec.flow != FLOW_SEQ) |=> st_q.dummy ##2 nop_body)
    else $error("flow change lacks nop cycle");
  rotate_flags_a: assert property ((exec && (st_q.dec.op == OP_ROT_L || st_q.dec.op == OP_ROT_R))
    |=> $stable(st_q.flags.zero) && st_q.flags.carry == $past(alu_o.carry))
    else $error("rotate touched wrong flag");
  skip_zero_a: assert property ((exec && st_q.dec.skip == SKIP_ZERO && alu_o.zero)
    |=> st_q.dummy && $stable(st_q.flags))
    else $error("skip on zero wrong");
  test_high_a: assert property ((exec && st_q.dec.skip == SKIP_BIT_HIGH)
    |=> st_q.dummy == $past(file_rd_data[st_q.dec.bitpos]))
    else $error("test skip high wrong");
  bit_set_a: assert property ((exec && st_q.dec.op == OP_BSET)
    |=> file_req.wr_data == ($past(operand) | (DATA_W'(1) << st_q.dec.bitpos)))
    else $error("bit set hit wrong bit");
  retval_a: assert property ((exec && st_q.instr[13:10] == {FMT_LIT, LOP_RETV})
    |=> st_q.acc == st_q.instr[LIT_W-1:0] && st_q.dummy)
    else $error("return with value wrong");
  standby_a: assert property ((exec && st_q.instr == WORD_STANDBY)
    |=> standby && !st_q.flags.sleep_entered_flag && st_q.flags.watchdog_expired_flag)
    else $error("standby word flags wrong");
  jump_target_a: assert property ((exec && st_q.instr[13:11] == 3'h5)
    |=> prog_addr == PC_W'(st_q.instr[JUMP_W-1:0]))
    else $error("jump target wrong");
endmodule : instr_sequencer

// ==== bench/prog_mem_model.sv ====
module prog_mem_model
  import core_pkg::*;
(
  input  wire logic               clk,
  input  wire logic [PC_W-1:0]    prog_addr,
  output logic [INSTR_W-1:0]      prog_word,
  input  wire file_req_t          file_req,
  output logic [DATA_W-1:0]       file_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [INSTR_W-1:0] rom [0:31];   // Program words, loaded by the bench
  logic [DATA_W-1:0]  regs [0:127]; // File registers behind the core
  // Fetch; anything past the table reads as a nop
  assign prog_word = (prog_addr < 13'h0020) ? rom[prog_addr[4:0]] : 14'h0000;
  // Read data valid in Q3 only; scrambled after, so stale use shows up
  always @(posedge clk) begin
    if (file_req.rd_en) begin
      file_rd_data <= regs[file_req.addr];
    end else begin
      file_rd_data <= ~file_rd_data;
    end
    if (file_req.wr_en) begin
      regs[file_req.addr] <= file_req.wr_data;
    end
  end
endmodule : prog_mem_model

// ==== bench/fourteen_bit_instruction_decoder_tb_top.sv ====
module fourteen_bit_instruction_decoder_tb_top;
  import core_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [PC_W-1:0] prog_addr;
  logic [INSTR_W-1:0] prog_word;
  file_req_t file_req;
  logic [DATA_W-1:0] file_rd_data, reg_wdata = 8'h00, reg_rdata;
  logic [REG_ADDR_W-1:0] reg_addr = 2'h0;
  logic reg_write = 1'b0, reg_read = 1'b0, rd_seen = 1'b0, wake_req = 1'b0;
  logic standby, watchdog_clear, irq_reenable;
  int failures = 0, check_count = 0, cycles = 0, wdog_n = 0, irq_n = 0;
  logic [14:0] exp_w[$]; // Expected file writes {addr, data}
  logic [7:0]  exp_r[$]; // Expected register read data
  logic [7:0]  k1, k2, k3, k4;
  logic [8:0]  sum;
  // Clock, 10 ns period
  always #5 clk = ~clk;
  instr_sequencer uut (.clk(clk), .rst_n(rst_n), .prog_addr(prog_addr),
    .prog_word(prog_word), .file_req(file_req), .file_rd_data(file_rd_data),
    .wake_req(wake_req), .standby(standby), .watchdog_clear(watchdog_clear),
    .irq_reenable(irq_reenable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  prog_mem_model pm (.clk(clk), .prog_addr(prog_addr), .prog_word(prog_word),
    .file_req(file_req), .file_rd_data(file_rd_data));
  task automatic check(string name, logic [14:0] exp, logic [14:0] got);
    check_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask : check
  task automatic end_of_test;
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // One-cycle register access; read data expected in the next cycle
  task automatic reg_op(logic wr, logic [1:0] a, logic [7:0] d);
    reg_write <= wr;
    reg_read <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask : reg_op
  // Strobes low after the last access, so back-to-back calls never assign them twice
  task automatic reg_idle;
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    @(posedge clk);
  endtask : reg_idle
  // Monitor: file writes in Q4 and register read data
  always @(posedge clk) begin
    if (file_req.wr_en) begin
      check("file_write", exp_w.size() ? exp_w.pop_front() : 15'h7fff,
            {file_req.addr, file_req.wr_data});
    end
    if (rd_seen) begin
      check("reg_rdata", {7'h00, exp_r.pop_front()}, {7'h00, reg_rdata});
    end
    rd_seen <= reg_read;
    // Pulse counters, compared at the end
    if (watchdog_clear === 1'b1) wdog_n++;
    if (irq_reenable === 1'b1) irq_n++;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h21d50473));
    k1 = 8'($urandom());
    k2 = 8'($urandom());
    k3 = 8'($urandom());
    k4 = 8'($urandom());
    foreach (pm.regs[i]) pm.regs[i] = 8'h00;
    pm.file_rd_data = 8'h5a;
    // Literal ops with loose bits set, stores, xor, inc-skip, bit ops, add, rotate,
    // calls to a value return, a kick and an interrupt return, standby, clear, halt loop
    pm.rom = '{14'h3300 | k1, 14'h0090, 14'h0690, 14'h0f90, 14'h1791, 14'h1f91, 14'h0092,
               14'h3f00 | k2, 14'h0093, 14'h0d93, 14'h2018, 14'h3800 | k4, 14'h0094,
               14'h2019, 14'h201b, 14'h0063, 14'h0195, 14'h2811, 14'h0, 14'h0, 14'h0,
               14'h0, 14'h0, 14'h0, 14'h3400 | k3, 14'h0064, 14'h0008, 14'h0009, 14'h0,
               14'h0, 14'h0, 14'h0};
    sum = k1 + k2;
    exp_w = '{{7'h10, k1}, {7'h10, 8'h00}, {7'h10, 8'h01}, {7'h11, 8'h80},
              {7'h13, sum[7:0]}, {7'h13, sum[6:0], sum[8]}, {7'h14, k3 | k4},
              {7'h15, 8'h00}};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    exp_r.push_back({3'b000, FLAGS_RESET});
    reg_op(1'b0, REG_STATUS, 8'h00);
    reg_op(1'b1, REG_CTRL, 8'h01);
    reg_idle();
    // Program parks in standby well inside this wait
    repeat (200) @(posedge clk);
    check("standby", 15'h0001, {14'h0000, standby});
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    repeat (40) @(posedge clk);
    check("standby", 15'h0000, {14'h0000, standby});
    // Accumulator is read-only from the port; write must be refused
    reg_op(1'b1, REG_ACC, ~(k3 | k4));
    exp_r.push_back(k3 | k4);
    reg_op(1'b0, REG_ACC, 8'h00);
    exp_r.push_back({5'b00010, 1'b1, (k1[3:0] + k2[3:0]) > 5'h0f, sum[7]});
    reg_op(1'b0, REG_STATUS, 8'h00);
    // Halt; the parked counter then sits on the jump word
    reg_op(1'b1, REG_CTRL, 8'h00);
    reg_idle();
    repeat (10) @(posedge clk);
    exp_r.push_back(8'h00);
    reg_op(1'b0, REG_CTRL, 8'h00);
    exp_r.push_back(8'h11);
    reg_op(1'b0, REG_PC_LO, 8'h00);
    reg_idle();
    repeat (3) @(posedge clk);
    check("kick_pulses", 15'h0002, 15'(wdog_n));
    check("iret_pulses", 15'h0001, 15'(irq_n));
    check("queues", 15'h0, 15'(exp_w.size() + exp_r.size()));
    end_of_test();
  end
endmodule : fourteen_bit_instruction_decoder_tb_top
